// >>> design/lcc_pkg.sv
// Register map, field layout and reset values of the laser current configuration check
package lcc_pkg;

  localparam int unsigned LCC_AW = 6;
  localparam int unsigned LCC_DW = 8;

  // Register offsets
  localparam logic [LCC_AW-1:0] LCC_ADDR_CTRL      = 6'h1A;
  localparam logic [LCC_AW-1:0] LCC_ADDR_CODE      = 6'h1C;
  localparam logic [LCC_AW-1:0] LCC_ADDR_CODE_INV  = 6'h1D;
  localparam logic [LCC_AW-1:0] LCC_ADDR_CTRL_INV  = 6'h1F;
  localparam logic [LCC_AW-1:0] LCC_ADDR_OBSERVE   = 6'h2E;

  // Reset values
  localparam logic [LCC_DW-1:0] LCC_RST_CTRL       = 8'h00;
  localparam logic [LCC_DW-1:0] LCC_RST_CODE       = 8'h00;
  localparam logic [LCC_DW-1:0] LCC_RST_CODE_INV   = 8'hFF;
  localparam logic [LCC_DW-1:0] LCC_RST_CTRL_INV   = 8'hA0;
  localparam logic [LCC_DW-1:0] LCC_RST_OBSERVE    = 8'h00;
  localparam logic [LCC_DW-1:0] LCC_READ_UNMAPPED  = 8'h00;

  // Laser control fields
  localparam int unsigned       LCC_CTRL_RANGE_BIT = 7;
  localparam int unsigned       LCC_CTRL_MATCH_BIT = 5;
  localparam int unsigned       LCC_CTRL_FDIS_BIT  = 0;
  localparam int unsigned       LCC_CTRL_CAL_HI    = 3;
  localparam int unsigned       LCC_CTRL_CAL_LO    = 1;
  localparam logic [LCC_DW-1:0] LCC_CTRL_PAIR_MASK = 8'hA0;
  localparam logic [LCC_DW-1:0] LCC_CODE_PAIR_MASK = 8'hFF;

  // Observation fields
  localparam logic [4:0]        LCC_OBS_ALL_SET    = 5'h1F;
  localparam logic [4:0]        LCC_OBS_CLEARED    = 5'h00;
  localparam logic [0:0]        LCC_OBS_RSVD       = 1'h0;

  // Relative current is (offset + code) / 384: code 0 is 129/384, code 255 is 384/384
  localparam logic [8:0]        LCC_CUR_OFFSET     = 9'h081;
  localparam logic [8:0]        LCC_CUR_FULL_SCALE = 9'h180;

  typedef enum logic [1:0] {
    LCC_ST_RUN   = 2'h0,
    LCC_ST_REST1 = 2'h1,
    LCC_ST_REST2 = 2'h2,
    LCC_ST_REST3 = 2'h3
  } lcc_op_state_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [LCC_AW-1:0] addr;
    logic [LCC_DW-1:0] wdata;
  } lcc_reg_req_t;

endpackage : lcc_pkg

// >>> design/lcc_pair_check.sv
// Complement check between a primary register and its companion over a bit mask
`timescale 1ns/100ps
module lcc_pair_check
  import lcc_pkg::*;
#(
  parameter int unsigned         W    = 8,
  parameter logic [W-1:0]        MASK = '1
) (
  input  wire logic [W-1:0] primary,
  input  wire logic [W-1:0] companion,
  output logic              match
);

  if (W == 0) begin : g_bad_width
    $error("lcc_pair_check: width must be at least one");
  end

  // Every masked bit must differ; unmasked bits are free
  assign match = (((primary ^ companion) & MASK) == MASK);

endmodule : lcc_pair_check

// >>> design/lcc_top.sv
// Laser current configuration with complement protection and frame observation
// Operation
// (R01) An 8-bit current code register drives the laser current DAC input.
// (R02) DAC is linear: code 0 is 33.59 percent, all-ones 100, step 1/384.
// (R03) Software writes the inverse code to 0x1D whenever it writes 0x1C.
// (R04) Code and companion not inverse: laser off, setting valid flag cleared.
// (R05) Either register of each pair may be written first after reset.
// (R06) Control bits 7 and 5 need inverses in 0x1F, else laser off, flag cleared.
// (R07) Checked continuously; matching pairs again re-enable laser and set flag. The code re-enables the laser only while control bit 0 is clear.
// (R08) Frame activity bits set every frame; any write to observation clears them. In the code, a frame in the same cycle as the write wins.
// (R09) Operating state field: run 00, rest1 01, rest2 10, rest3 11.
`timescale 1ns/100ps
module lcc_top
  import lcc_pkg::*;
#(
  parameter logic [LCC_DW-1:0] RST_CODE     = LCC_RST_CODE,
  parameter logic [LCC_DW-1:0] RST_CODE_INV = LCC_RST_CODE_INV,
  parameter logic [LCC_DW-1:0] RST_CTRL_INV = LCC_RST_CTRL_INV
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire lcc_reg_req_t      reg_req,
  output logic [LCC_DW-1:0]      reg_rdata,
  output logic                   reg_rvalid,
  input  wire logic              frame_tick,
  input  wire lcc_op_state_t     operating_state_field,
  output logic [LCC_DW-1:0]      laser_dac_code,
  output logic [8:0]             laser_rel_current,
  output logic                   laser_enable,
  output logic                   laser_setting_valid,
  output logic                   laser_range,
  output logic                   laser_match,
  output logic [2:0]             laser_cal_mode
);

  // Register file
  logic [LCC_DW-1:0] ctrl_q;
  logic [LCC_DW-1:0] ctrl_d;
  logic [LCC_DW-1:0] code_q;
  logic [LCC_DW-1:0] code_d;
  logic [LCC_DW-1:0] code_inv_q;
  logic [LCC_DW-1:0] code_inv_d;
  logic [LCC_DW-1:0] ctrl_inv_q;
  logic [LCC_DW-1:0] ctrl_inv_d;

  // Observation
  logic [4:0]        obs_q;
  logic [4:0]        obs_d;
  logic [1:0]        mode_q;
  logic [1:0]        mode_d;

  // Read port
  logic [LCC_DW-1:0] rdata_q;
  logic [LCC_DW-1:0] rdata_d;
  logic              rvalid_q;
  logic              rvalid_d;

  // Laser drive
  logic [LCC_DW-1:0] dac_q;
  logic [LCC_DW-1:0] dac_d;
  logic [8:0]        cur_q;
  logic [8:0]        cur_d;
  logic              en_q;
  logic              en_d;
  logic              valid_q;
  logic              valid_d;
  logic              code_match;
  logic              ctrl_match;

  // Elaboration checks: refuse a layout with an unprotected code bit, a wrong full scale or misfit control fields
  if (LCC_CODE_PAIR_MASK != '1) begin : g_bad_code_mask
    $error("lcc_top: every bit of the current code must be protected");
  end
  if (LCC_CUR_OFFSET + {1'b0, LCC_CODE_PAIR_MASK} != LCC_CUR_FULL_SCALE) begin : g_bad_scale
    $error("lcc_top: the all-ones code must reach full scale");
  end
  if (LCC_CTRL_RANGE_BIT >= LCC_DW || LCC_CTRL_MATCH_BIT >= LCC_DW) begin : g_bad_ctrl
    $error("lcc_top: a protected control bit lies outside the register");
  end
  if (LCC_CTRL_CAL_HI - LCC_CTRL_CAL_LO + 1 != $bits(laser_cal_mode)) begin : g_bad_cal
    $error("lcc_top: the calibration field must match its output width");
  end

  // Code pair: all eight bits must be inverted
  lcc_pair_check #(
    .W    (LCC_DW),
    .MASK (LCC_CODE_PAIR_MASK)
  ) u_code_check (
    .primary   (code_q),
    .companion (code_inv_q),
    .match     (code_match)
  );  // [R04]

  // Control pair: only range and match are protected, the rest is free
  lcc_pair_check #(
    .W    (LCC_DW),
    .MASK (LCC_CTRL_PAIR_MASK)
  ) u_ctrl_check (
    .primary   (ctrl_q),
    .companion (ctrl_inv_q),
    .match     (ctrl_match)
  );  // [R06]

  // Register writes: each register stands alone, so no pair imposes a write order
  always_comb begin
    ctrl_d     = ctrl_q;
    code_d     = code_q;
    code_inv_d = code_inv_q;
    ctrl_inv_d = ctrl_inv_q;
    if (reg_req.wr) begin
      case (reg_req.addr)
        LCC_ADDR_CTRL:     ctrl_d     = reg_req.wdata;  // [R05]
        LCC_ADDR_CODE:     code_d     = reg_req.wdata;  // [R01] [R05]
        LCC_ADDR_CODE_INV: code_inv_d = reg_req.wdata;  // [R05]
        LCC_ADDR_CTRL_INV: ctrl_inv_d = reg_req.wdata;  // [R05]
        default: begin
        end
      endcase
    end
  end

  // Observation: a frame in the same cycle as a clearing write wins, so no frame is lost
  always_comb begin
    obs_d  = obs_q;
    mode_d = operating_state_field;  // [R09]
    if (reg_req.wr && (reg_req.addr == LCC_ADDR_OBSERVE)) begin
      obs_d = LCC_OBS_CLEARED;  // [R08]
    end
    if (frame_tick) begin
      obs_d = LCC_OBS_ALL_SET;  // [R08]
    end
  end

  // Laser drive follows the check every cycle, so restoring both pairs recovers it while control bit 0 is clear
  always_comb begin
    valid_d = code_match && ctrl_match;  // [R04] [R06] [R07]
    en_d    = valid_d && !ctrl_q[LCC_CTRL_FDIS_BIT];  // [R04] [R06] [R07]
    dac_d   = code_q;  // [R01]
    cur_d   = LCC_CUR_OFFSET + {1'b0, code_q};  // [R02]
  end

  // Reads answer one cycle after the request; unmapped offsets read as zero
  always_comb begin
    rvalid_d = reg_req.rd;
    rdata_d  = rdata_q;
    if (reg_req.rd) begin
      case (reg_req.addr)
        LCC_ADDR_CTRL:     rdata_d = ctrl_q;
        LCC_ADDR_CODE:     rdata_d = code_q;
        LCC_ADDR_CODE_INV: rdata_d = code_inv_q;
        LCC_ADDR_CTRL_INV: rdata_d = ctrl_inv_q;
        LCC_ADDR_OBSERVE:  rdata_d = {mode_q, LCC_OBS_RSVD, obs_q};  // [R08] [R09]
        default:           rdata_d = LCC_READ_UNMAPPED;
      endcase
    end
  end

  // Register file: default reset values of both pairs agree, so the laser may start on
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= LCC_RST_CTRL;
      code_q     <= RST_CODE;
      code_inv_q <= RST_CODE_INV;
      ctrl_inv_q <= RST_CTRL_INV;
    end else begin
      ctrl_q     <= ctrl_d;
      code_q     <= code_d;
      code_inv_q <= code_inv_d;
      ctrl_inv_q <= ctrl_inv_d;
    end
  end

  // Observation
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      obs_q  <= LCC_OBS_CLEARED;
      mode_q <= LCC_ST_RUN;
    end else begin
      obs_q  <= obs_d;
      mode_q <= mode_d;
    end
  end

  // Read port: data hold between reads, so a slow host still sees the answer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q  <= LCC_READ_UNMAPPED;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Laser drive: held off in reset until the first check has been registered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_q   <= RST_CODE;
      cur_q   <= LCC_CUR_OFFSET;
      en_q    <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      dac_q   <= dac_d;
      cur_q   <= cur_d;
      en_q    <= en_d;
      valid_q <= valid_d;
    end
  end

  assign reg_rdata           = rdata_q;
  assign reg_rvalid          = rvalid_q;
  assign laser_dac_code      = dac_q;
  assign laser_rel_current   = cur_q;
  assign laser_enable        = en_q;
  assign laser_setting_valid = valid_q;
  // Control fields leave straight from the register; the pair check gates only the laser
  assign laser_range         = ctrl_q[LCC_CTRL_RANGE_BIT];
  assign laser_match         = ctrl_q[LCC_CTRL_MATCH_BIT];
  assign laser_cal_mode      = ctrl_q[LCC_CTRL_CAL_HI:LCC_CTRL_CAL_LO];

endmodule : lcc_top

// >>> dv/lcc_checker.sv
// Port assertions for the laser current configuration check
`timescale 1ns/100ps
module lcc_checker
  import lcc_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire lcc_reg_req_t      reg_req,
  input wire logic [LCC_DW-1:0] reg_rdata,
  input wire logic              reg_rvalid,
  input wire logic              frame_tick,
  input wire lcc_op_state_t     operating_state_field,
  input wire logic [LCC_DW-1:0] laser_dac_code,
  input wire logic [8:0]        laser_rel_current,
  input wire logic              laser_enable,
  input wire logic              laser_setting_valid,
  input wire logic              laser_range,
  input wire logic              laser_match
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic rd_obs;
  assign rd_obs = reg_req.rd && reg_req.addr == LCC_ADDR_OBSERVE;
  property p_dac;
    reg_req.wr && reg_req.addr == LCC_ADDR_CODE |-> ##2 laser_dac_code == $past(reg_req.wdata, 2);
  endproperty
  a_dac: assert property (p_dac) else $error("dac code wrong");
  property p_rel;
    laser_rel_current == LCC_CUR_OFFSET + {1'b0, laser_dac_code};
  endproperty
  a_rel: assert property (p_rel) else $error("current wrong");
  property p_en;
    laser_enable |-> laser_setting_valid;
  endproperty
  a_en: assert property (p_en) else $error("laser on while invalid");
  property p_fell;
    $fell(laser_setting_valid) |-> $past(reg_req.wr, 2);
  endproperty
  a_fell: assert property (p_fell) else $error("valid fell unprompted");
  property p_rv;
    reg_rvalid == $past(reg_req.rd);
  endproperty
  a_rv: assert property (p_rv) else $error("read valid wrong");
  property p_mode;
    rd_obs |=> reg_rdata[7:5] == {$past(operating_state_field, 2), 1'b0};
  endproperty
  a_mode: assert property (p_mode) else $error("state field wrong");
  property p_frm;
    frame_tick ##1 rd_obs |=> reg_rdata[4:0] == LCC_OBS_ALL_SET;
  endproperty
  a_frm: assert property (p_frm) else $error("activity bits not set");
  property p_rng;
    reg_req.wr && reg_req.addr == LCC_ADDR_CTRL |=> laser_range == $past(reg_req.wdata[7]);
  endproperty
  a_rng: assert property (p_rng) else $error("range bit wrong");
  property p_mat;
    reg_req.wr && reg_req.addr == LCC_ADDR_CTRL |=> laser_match == $past(reg_req.wdata[5]);
  endproperty
  a_mat: assert property (p_mat) else $error("match bit wrong");
endmodule : lcc_checker

bind lcc_top lcc_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .frame_tick(frame_tick),
  .operating_state_field(operating_state_field), .laser_dac_code(laser_dac_code),
  .laser_rel_current(laser_rel_current), .laser_enable(laser_enable),
  .laser_setting_valid(laser_setting_valid), .laser_range(laser_range),
  .laser_match(laser_match));

// >>> dv/tb_top.sv
// Self-checking bench for the laser current configuration check
`timescale 1ns/100ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module tb_top
  import lcc_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  lcc_reg_req_t      req = '0;
  logic              frame_tick = 1'b0;
  lcc_op_state_t     mode = LCC_ST_RUN;
  logic [LCC_DW-1:0] rdata, dac;
  logic [8:0]        rel;
  logic              rvalid, en, valid;
  logic              rng, mat;
  logic [2:0]        cal;
  int                err_total = 0, num_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  lcc_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .frame_tick(frame_tick), .operating_state_field(mode),
    .laser_dac_code(dac), .laser_rel_current(rel), .laser_enable(en),
    .laser_setting_valid(valid), .laser_range(rng), .laser_match(mat), .laser_cal_mode(cal));
  // Returns after the flag has had its two cycles to follow the write
  task automatic wr(input logic [LCC_AW-1:0] a, input logic [LCC_DW-1:0] d);
    @(posedge ref_clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk) req.wr <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [LCC_AW-1:0] a, input logic [LCC_DW-1:0] e);
    @(posedge ref_clk) begin
      frame_tick <= 1'b0;
      req <= '{1'b0, 1'b1, a, 8'h00};
    end
    @(posedge ref_clk) req.rd <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask : rd
  task automatic st(input logic v, input logic e, input logic [LCC_DW-1:0] c);
    `CHK("valid", v, valid)
    `CHK("enable", e, en)
    `CHK("dac", c, dac)
    `CHK("current", LCC_CUR_OFFSET + {1'b0, c}, rel)
  endtask : st
  task results;
    $display("Checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(LCC_ADDR_CODE_INV, LCC_RST_CODE_INV);
    rd(LCC_ADDR_CTRL_INV, LCC_RST_CTRL_INV);
    rd(6'h30, LCC_READ_UNMAPPED);
    st(1'b1, 1'b1, 8'h00);
    wr(LCC_ADDR_CODE, 8'h10);
    st(1'b0, 1'b0, 8'h10);
    wr(LCC_ADDR_CODE_INV, 8'hEF);
    st(1'b1, 1'b1, 8'h10);
    wr(LCC_ADDR_CODE_INV, 8'h00);
    st(1'b0, 1'b0, 8'h10);
    wr(LCC_ADDR_CODE, 8'hFF);
    st(1'b1, 1'b1, 8'hFF);
    rd(LCC_ADDR_CODE, 8'hFF);
    wr(LCC_ADDR_CTRL, 8'h80);
    st(1'b0, 1'b0, 8'hFF);
    wr(LCC_ADDR_CTRL_INV, 8'h3F);
    st(1'b1, 1'b1, 8'hFF);
    wr(LCC_ADDR_CTRL, 8'h81);
    st(1'b1, 1'b0, 8'hFF);
    `CHK("range", 1'b1, rng)
    `CHK("match", 1'b0, mat)
    `CHK("cal", 3'h0, cal)
    wr(LCC_ADDR_CTRL, 8'h2E);
    st(1'b0, 1'b0, 8'hFF);
    `CHK("range", 1'b0, rng)
    `CHK("match", 1'b1, mat)
    `CHK("cal", 3'h7, cal)
    wr(LCC_ADDR_CTRL_INV, 8'h9F);
    st(1'b1, 1'b1, 8'hFF);
    @(posedge ref_clk) frame_tick <= 1'b1;
    rd(LCC_ADDR_OBSERVE, {3'h0, LCC_OBS_ALL_SET});
    wr(LCC_ADDR_OBSERVE, 8'h5A);
    rd(LCC_ADDR_OBSERVE, 8'h00);
    for (int m = 0; m < 4; m++) begin
      @(posedge ref_clk) mode <= lcc_op_state_t'(m);
      rd(LCC_ADDR_OBSERVE, {m[1:0], 6'h00});
    end
    results();
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    err_total++;
    results();
  end
endmodule : tb_top
